/* File: rtl/pscr_pkg.sv */
// Package for the paged system configuration register bank.
// Assumes an 8-bit register port from the control interface front end.
package pscr_pkg;

  // ****************************************************************
  // Register offsets and widths
  // ****************************************************************
  localparam int          PSCR_DW          = 8;
  localparam logic [7:0]  PSCR_OFF_PAGE    = 8'h00;
  localparam logic [7:0]  PSCR_OFF_RESET   = 8'h01;
  localparam logic [7:0]  PSCR_OFF_REFCFG  = 8'h02;
  localparam logic [7:0]  PSCR_OFF_SUPPLY  = 8'h03;
  localparam logic [7:0]  PSCR_OFF_BCAST   = 8'h04;
  localparam logic [7:0]  PSCR_PAGE_CFG    = 8'h00;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [7:0]  PSCR_RST_VAL     = 8'h00;
  localparam int          PSCR_SRST_BIT    = 0;
  localparam int          PSCR_QCHG_LSB    = 4;
  localparam int          PSCR_WAKEREF_BIT = 3;
  localparam int          PSCR_AMODE_BIT   = 2;
  localparam int          PSCR_IOMODE_BIT  = 1;
  localparam int          PSCR_WAKE_BIT    = 0;
  localparam int          PSCR_AFORCE_BIT  = 7;
  localparam int          PSCR_IOFORCE_BIT = 6;
  localparam int          PSCR_UVSD_BIT    = 1;
  localparam int          PSCR_UVWAKE_BIT  = 0;
  localparam int          PSCR_BCAST_BIT   = 1;
  // Writable-bit masks; host writes cannot change other bits
  localparam logic [7:0]  PSCR_MASK_RESET  = 8'h01;
  localparam logic [7:0]  PSCR_MASK_REFCFG = 8'hff;
  localparam logic [7:0]  PSCR_MASK_SUPPLY = 8'h01;
  localparam logic [7:0]  PSCR_MASK_BCAST  = 8'hff;

  // ****************************************************************
  // Timing: quick-charge durations in microseconds, clock 20 MHz
  // ****************************************************************
  localparam int          PSCR_CLK_HZ      = 20000000;
  localparam int          PSCR_QCHG0_US    = 3500;
  localparam int          PSCR_QCHG1_US    = 10000;
  localparam int          PSCR_QCHG2_US    = 50000;
  localparam int          PSCR_QCHG3_US    = 100000;
  localparam int          PSCR_CYC_PER_US  = PSCR_CLK_HZ / 1000000;

  // Register port request carried as one struct
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pscr_req_t;

  // Supply condition inputs from the analog monitors
  typedef struct packed {
    logic analog_high;
    logic io_high;
    logic undervoltage;
  } pscr_sup_t;

endpackage

/* File: rtl/pscr_qchg_timer.sv */
// Quick-charge timer: counts the selected duration once started.
// Assumes a single 20 MHz clock and a one-cycle start pulse.
`timescale 1ns/1ps
module pscr_qchg_timer
  import pscr_pkg::*;
#(
  parameter int QCHG0_CYC = PSCR_QCHG0_US * PSCR_CYC_PER_US,
  parameter int QCHG1_CYC = PSCR_QCHG1_US * PSCR_CYC_PER_US,
  parameter int QCHG2_CYC = PSCR_QCHG2_US * PSCR_CYC_PER_US,
  parameter int QCHG3_CYC = PSCR_QCHG3_US * PSCR_CYC_PER_US
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clear_i,
  input  wire logic       start_i,
  input  wire logic [1:0] sel_i,
  output logic            busy_o
);

  logic [21:0] cnt_q;
  logic [21:0] cnt_d;
  logic [21:0] load;

  // ****************************************************************
  // Duration select and down counter
  // ****************************************************************
  always_comb begin
    case (sel_i)
      2'h0:    load = 22'(QCHG0_CYC);
      2'h1:    load = 22'(QCHG1_CYC);
      2'h2:    load = 22'(QCHG2_CYC);
      default: load = 22'(QCHG3_CYC);
    endcase
    cnt_d = cnt_q;
    if (clear_i) begin
      cnt_d = '0;
    end else if (start_i) begin
      cnt_d = load;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 22'h1;
    end
  end

  // Counter register; busy taken from the registered count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy_o = (cnt_q != '0);

endmodule

/* File: rtl/pscr_regs.sv */
// Paged system configuration registers, offsets 0 to 4 of the map.
// Assumes the control interface front end delivers single-cycle
// read and write strobes with an 8-bit offset, synchronous to clk_i.
//
// Behaviour
// - Page selector at offset zero, 8 bits
// - Soft reset bit resets all, self clears
// - Soft reset equals power-on defaults, except an undervoltage event in the same cycle stays flagged
// - Quick-charge field selects four durations
// - Wake-with-reference bit chooses enables on wake
// - Analog supply mode bit selects regulator
// - I/O supply mode bit selects speed
// - Wake control bit, reset keeps sleep
// - Analog forced flag reports supply override
// - I/O forced flag reports supply override
// - Undervoltage shutdown flag reports past event
// - Undervoltage wake select decides post-shutdown state
// - Broadcast enable bit accepts broadcast address
`timescale 1ns/1ps
module pscr_regs
  import pscr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire pscr_req_t   req_i,
  input  wire pscr_sup_t   sup_i,
  output logic [7:0]       rdata_o,
  output logic             rvalid_o,
  output logic [7:0]       page_o,
  output logic             digital_regulator_en_o,
  output logic             reference_en_o,
  output logic             analog_supply_mode_o,
  output logic             io_supply_mode_o,
  output logic             reference_charging_o,
  output logic             broadcast_address_enable_o,
  output logic             undervoltage_shutdown_flag_o
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0] page_q, page_d;
  logic [7:0] refcfg_q, refcfg_d;
  logic [7:0] bcast_q, bcast_d;
  logic       uvwake_q, uvwake_d;
  logic       uvsd_q, uvsd_d;
  logic       srst_q, srst_d;
  logic       asleep_q, asleep_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  logic       digital_regulator_q, digital_regulator_d;
  logic       vref_q, vref_d;
  logic       amode_q, amode_d;
  logic       iomode_q, iomode_d;
  logic       chg_q;
  logic       uv_prev_q;
  logic       wr_here;
  logic       page0;
  logic       uv_rise;
  logic       wake_now;
  logic       qchg_busy;
  logic [7:0] status;

  // Only page 0 holds this bank, but the selector answers on any page
  assign page0   = (page_q == PSCR_PAGE_CFG);
  assign wr_here = req_i.wr && (page0 || req_i.addr == PSCR_OFF_PAGE);
  assign uv_rise = sup_i.undervoltage && !uv_prev_q;

  // Status view: forced flags are live, reserved bits read zero
  always_comb begin
    status                   = PSCR_RST_VAL;
    status[PSCR_AFORCE_BIT]  = sup_i.analog_high;
    status[PSCR_IOFORCE_BIT] = sup_i.io_high;
    status[PSCR_UVSD_BIT]    = uvsd_q;
    status[PSCR_UVWAKE_BIT]  = uvwake_q;
  end

  // ****************************************************************
  // Next-state logic for registers and read port
  // ****************************************************************
  always_comb begin
    page_d   = page_q;
    refcfg_d = refcfg_q;
    bcast_d  = bcast_q;
    uvwake_d = uvwake_q;
    uvsd_d   = uvsd_q || uv_rise;
    srst_d   = 1'b0;
    rdata_d  = PSCR_RST_VAL;
    rvalid_d = req_i.rd;
    // Masks drop host writes to bits outside them; the REFCFG and BCAST masks pass all 8 bits
    if (wr_here) begin
      case (req_i.addr)
        PSCR_OFF_PAGE:   page_d = req_i.wdata;
        PSCR_OFF_RESET:  srst_d = req_i.wdata[PSCR_SRST_BIT] & PSCR_MASK_RESET[PSCR_SRST_BIT];
        PSCR_OFF_REFCFG: refcfg_d = req_i.wdata & PSCR_MASK_REFCFG;
        PSCR_OFF_SUPPLY: uvwake_d = req_i.wdata[PSCR_UVWAKE_BIT] & PSCR_MASK_SUPPLY[PSCR_UVWAKE_BIT];
        PSCR_OFF_BCAST:  bcast_d = req_i.wdata & PSCR_MASK_BCAST;
        default:         page_d = page_q;
      endcase
    end
    if (req_i.rd && (page0 || req_i.addr == PSCR_OFF_PAGE)) begin
      case (req_i.addr)
        PSCR_OFF_PAGE:   rdata_d = page_q;
        PSCR_OFF_RESET:  rdata_d = {7'h00, srst_q};
        PSCR_OFF_REFCFG: rdata_d = refcfg_q;
        PSCR_OFF_SUPPLY: rdata_d = status;
        PSCR_OFF_BCAST:  rdata_d = bcast_q;
        default:         rdata_d = PSCR_RST_VAL;
      endcase
    end
  end

  // ****************************************************************
  // Sleep control and derived enables
  // ****************************************************************
  // Undervoltage forces sleep; the wake select decides the return
  assign wake_now = refcfg_q[PSCR_WAKE_BIT] && !sup_i.undervoltage;
  always_comb begin
    asleep_d = asleep_q;
    if (sup_i.undervoltage) begin
      asleep_d = 1'b1;
    end else if (uvsd_q && asleep_q && uvwake_q) begin
      asleep_d = 1'b0;
    end else if (!uvsd_q || !asleep_q) begin
      asleep_d = !wake_now;
    end
    digital_regulator_d   = !asleep_d;
    vref_d   = !asleep_d && refcfg_q[PSCR_WAKEREF_BIT];
    // Forced flags override the configured modes back to zero
    amode_d  = refcfg_q[PSCR_AMODE_BIT] && !sup_i.analog_high;
    iomode_d = refcfg_q[PSCR_IOMODE_BIT] && !sup_i.io_high;
  end

  // Quick charge starts when the reference is first enabled
  pscr_qchg_timer u_qchg (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clear_i (srst_q),
    .start_i (vref_d && !vref_q),
    .sel_i   (refcfg_q[PSCR_QCHG_LSB +: 2]),
    .busy_o  (qchg_busy)
  );

  // ****************************************************************
  // Registers; soft reset acts one cycle after the write, like POR
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_q    <= PSCR_RST_VAL;
      refcfg_q  <= PSCR_RST_VAL;
      bcast_q   <= PSCR_RST_VAL;
      uvwake_q  <= 1'b0;
      uvsd_q    <= 1'b0;
      srst_q    <= 1'b0;
      asleep_q  <= 1'b1;
      digital_regulator_q    <= 1'b0;
      vref_q    <= 1'b0;
      amode_q   <= 1'b0;
      iomode_q  <= 1'b0;
      chg_q     <= 1'b0;
      uv_prev_q <= 1'b0;
      rdata_q   <= PSCR_RST_VAL;
      rvalid_q  <= 1'b0;
    end else if (srst_q) begin
      page_q    <= PSCR_RST_VAL;
      refcfg_q  <= PSCR_RST_VAL;
      bcast_q   <= PSCR_RST_VAL;
      uvwake_q  <= 1'b0;
      uvsd_q    <= uv_rise;                         // Event in same cycle is kept
      srst_q    <= 1'b0;
      asleep_q  <= 1'b1;
      digital_regulator_q    <= 1'b0;
      vref_q    <= 1'b0;
      amode_q   <= 1'b0;
      iomode_q  <= 1'b0;
      chg_q     <= 1'b0;
      uv_prev_q <= sup_i.undervoltage;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
    end else begin
      page_q    <= page_d;
      refcfg_q  <= refcfg_d;
      bcast_q   <= bcast_d;
      uvwake_q  <= uvwake_d;
      uvsd_q    <= uvsd_d;
      srst_q    <= srst_d;
      asleep_q  <= asleep_d;
      digital_regulator_q    <= digital_regulator_d;
      vref_q    <= vref_d;
      amode_q   <= amode_d;
      iomode_q  <= iomode_d;
      chg_q     <= qchg_busy;
      uv_prev_q <= sup_i.undervoltage;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
    end
  end

  // Outputs straight from flip-flops
  assign page_o                       = page_q;
  assign rdata_o                      = rdata_q;
  assign rvalid_o                     = rvalid_q;
  assign digital_regulator_en_o       = digital_regulator_q;
  assign reference_en_o               = vref_q;
  assign analog_supply_mode_o         = amode_q;
  assign io_supply_mode_o             = iomode_q;
  assign reference_charging_o         = chg_q;
  assign broadcast_address_enable_o   = bcast_q[PSCR_BCAST_BIT];
  assign undervoltage_shutdown_flag_o = uvsd_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_srst_write;
    req_i.wr && page0 && req_i.addr == PSCR_OFF_RESET && req_i.wdata[0];
  endsequence
  sequence s_all_default;
    page_q == 8'h00 && refcfg_q == 8'h00 && bcast_q == 8'h00 && !uvwake_q;
  endsequence

  property p_page_write;
    @(posedge clk_i) disable iff (!rst_n_i)
      (req_i.wr && req_i.addr == PSCR_OFF_PAGE && !srst_q) |=> page_o == $past(req_i.wdata);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write lost");

  property p_srst;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_srst_write and !srst_q |=> srst_q ##1 (s_all_default and !srst_q);
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset sequence wrong");

  property p_srst_defaults;
    @(posedge clk_i) disable iff (!rst_n_i)
      srst_q |=> !digital_regulator_q && !vref_q && !amode_q && !iomode_q && !reference_charging_o;
  endproperty
  a_srst_defaults: assert property (p_srst_defaults) else $error("soft reset not default");

  property p_aforce;
    @(posedge clk_i) disable iff (!rst_n_i)
      (req_i.rd && req_i.addr == PSCR_OFF_SUPPLY && page0)
        |=> rdata_o[7:6] == $past({sup_i.analog_high, sup_i.io_high}) && rdata_o[5:2] == 4'h0;
  endproperty
  a_aforce: assert property (p_aforce) else $error("supply status readback wrong");

  property p_amode;
    @(posedge clk_i) disable iff (!rst_n_i)
      sup_i.analog_high && !srst_q |=> !analog_supply_mode_o;
  endproperty
  a_amode: assert property (p_amode) else $error("analog mode not forced");

  property p_iomode;
    @(posedge clk_i) disable iff (!rst_n_i)
      sup_i.io_high && !srst_q |=> !io_supply_mode_o;
  endproperty
  a_iomode: assert property (p_iomode) else $error("io mode not forced");

  property p_uvsd;
    @(posedge clk_i) disable iff (!rst_n_i)
      uv_rise && !(req_i.wr && req_i.addr == PSCR_OFF_RESET) |=> undervoltage_shutdown_flag_o [*2];
  endproperty
  a_uvsd: assert property (p_uvsd) else $error("undervoltage flag not held");

  property p_sleep;
    @(posedge clk_i) disable iff (!rst_n_i)
      sup_i.undervoltage |=> !digital_regulator_en_o && !reference_en_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");

  property p_vref_only_with_digital_regulator;
    @(posedge clk_i) disable iff (!rst_n_i)
      reference_en_o |-> digital_regulator_en_o && $past(refcfg_q[PSCR_WAKEREF_BIT]);
  endproperty
  a_vref_only_with_digital_regulator: assert property (p_vref_only_with_digital_regulator) else $error("reference without regulator");

  property p_ro_status;
    @(posedge clk_i) disable iff (!rst_n_i)
      (req_i.wr && req_i.addr == PSCR_OFF_SUPPLY && !uv_rise && !srst_q) |=> uvsd_q == $past(uvsd_q);
  endproperty
  a_ro_status: assert property (p_ro_status) else $error("read-only bit written");

endmodule

/* File: verif/pscr_host_model.sv */
// Host controller model that issues byte reads and writes to the bank.
// Assumes callers enter each task just after a rising edge of clk_i.
`timescale 1ns/1ps
module pscr_host
  import pscr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output pscr_req_t       req_o
);
  // ****************************************************************
  // Request driver
  // ****************************************************************
  initial req_o = '0;

  // Reserved bits are sent as zero at the reset and broadcast offsets only; other offsets pass data through
  function automatic logic [7:0] clean(input logic [7:0] a, input logic [7:0] d);
    if (a == PSCR_OFF_RESET) return d & PSCR_MASK_RESET;
    if (a == PSCR_OFF_BCAST) return d & 8'h02;
    return d;
  endfunction

  // Write strobe held through one taking edge; caller releases with idle
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: clean(a, d)};
    @(posedge clk_i);
  endtask

  // Drop all strobes for one cycle
  task automatic idle();
    req_o <= '0;
    @(posedge clk_i);
  endtask

  // Read answer lands one cycle after the strobe; sample once it settles
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req_o <= '0;
    #1;
    d = rdata_i;
    v = rvalid_i;
    @(posedge clk_i);
  endtask
endmodule

/* File: verif/pscr_regs_test.sv */
// Self-checking bench for the paged configuration register bank.
// Assumes a host model on the request port and supply levels from the bench.
`timescale 1ns/1ps
module pscr_regs_test;
  import pscr_pkg::*;
  logic       clk_i;
  logic       rst_n_i;
  pscr_req_t  req;
  pscr_sup_t  sup;
  logic [7:0] rdata;
  logic [7:0] page;
  logic       rvalid, digital_regulator, vref, amode, iomode, chg, bcast, uvflag;
  logic [7:0] d;
  int         n_mismatch;
  int         n_checks;

  // ****************************************************************
  // Instances
  // ****************************************************************
  pscr_host host_inst (
    .clk_i    (clk_i),
    .rdata_i  (rdata),
    .rvalid_i (rvalid),
    .req_o    (req));

  pscr_regs pscr_regs_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .sup_i(sup),
    .rdata_o(rdata), .rvalid_o(rvalid), .page_o(page),
    .digital_regulator_en_o(digital_regulator), .reference_en_o(vref),
    .analog_supply_mode_o(amode), .io_supply_mode_o(iomode),
    .reference_charging_o(chg), .broadcast_address_enable_o(bcast),
    .undervoltage_shutdown_flag_o(uvflag));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Second idle: checks taken at an edge see the state of the edge before,
  // so the enables derived from a written register need one more cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host_inst.write(a, v);
    host_inst.idle();
    host_inst.idle();
  endtask

  // Every read must come back with its valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic ok;
    host_inst.read(a, v, ok);
    chk(8'(ok), 8'h01);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_defaults();
    for (int a = 0; a < 6; a++) begin
      rd(8'(a), d);
      chk(d, PSCR_RST_VAL);
    end
    chk(8'(digital_regulator), 8'h00);
  endtask

  // Top page value, then a foreign page hides the config but not offset 0
  task automatic t_page();
    wr(PSCR_OFF_PAGE, 8'hff);
    chk(page, 8'hff);
    wr(PSCR_OFF_REFCFG, 8'h01);
    chk(8'(digital_regulator), 8'h00);
    rd(PSCR_OFF_PAGE, d);
    chk(d, 8'hff);
    host_inst.write(PSCR_OFF_PAGE, 8'h05);
    host_inst.write(PSCR_OFF_PAGE, 8'h00);
    host_inst.idle();
    chk(page, 8'h00);
  endtask

  task automatic t_refcfg();
    for (int q = 0; q < 4; q++) begin
      wr(PSCR_OFF_REFCFG, 8'(q << PSCR_QCHG_LSB));
      rd(PSCR_OFF_REFCFG, d);
      chk(d, 8'(q << PSCR_QCHG_LSB));
    end
    wr(PSCR_OFF_REFCFG, 8'h01);
    chk(8'({digital_regulator, vref}), 8'h02);
    wr(PSCR_OFF_REFCFG, 8'h0e);
    chk(8'({digital_regulator, vref, amode, iomode}), 8'h03);
    wr(PSCR_OFF_REFCFG, 8'h00);
  endtask

  // Shortest charge, 3.5 ms, must still run near its end and stop after
  task automatic t_charge();
    wr(PSCR_OFF_REFCFG, 8'h09);
    cyc(4);
    chk(8'({digital_regulator, vref}), 8'h03);
    chk(8'(chg), 8'h01);
    cyc(69000);
    chk(8'(chg), 8'h01);
    cyc(2000);
    chk(8'(chg), 8'h00);
    wr(PSCR_OFF_REFCFG, 8'h00);
  endtask

  task automatic t_status();
    wr(PSCR_OFF_REFCFG, 8'h06);
    sup <= '{analog_high: 1'b1, io_high: 1'b1, undervoltage: 1'b0};
    cyc(3);
    chk(8'({amode, iomode}), 8'h00);
    rd(PSCR_OFF_SUPPLY, d);
    chk(d, 8'hc0);
    sup <= '0;
    cyc(3);
    chk(8'({amode, iomode}), 8'h03);
    wr(PSCR_OFF_SUPPLY, 8'hfe);
    rd(PSCR_OFF_SUPPLY, d);
    chk(d, 8'h00);
  endtask

  // Shutdown while awake, wake select flipped, then soft reset clears all
  task automatic t_undervolt();
    wr(PSCR_OFF_REFCFG, 8'h01);
    wr(PSCR_OFF_BCAST, 8'h02);
    chk(8'(bcast), 8'h01);
    sup <= '{analog_high: 1'b0, io_high: 1'b0, undervoltage: 1'b1};
    cyc(3);
    sup <= '0;
    cyc(2);
    chk(8'({uvflag, digital_regulator}), 8'h02);
    wr(PSCR_OFF_SUPPLY, 8'h01);
    cyc(2);
    chk(8'(digital_regulator), 8'h01);
    rd(PSCR_OFF_SUPPLY, d);
    chk(d, 8'h03);
    wr(PSCR_OFF_RESET, 8'h01);
    chk(8'({uvflag, digital_regulator, bcast, amode}), 8'h00);
    for (int a = 1; a < 5; a++) begin
      rd(8'(a), d);
      chk(d, PSCR_RST_VAL);
    end
  endtask

  // ****************************************************************
  // Verdict, clock, reset and sequence
  // ****************************************************************
  task automatic results();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Whole run is about 71k cycles, so this leaves ample margin
  initial begin
    cyc(90000);
    n_mismatch++;
    results();
  end

  initial begin
    rst_n_i = 1'b0;
    sup = '0;
    n_mismatch = 0;
    n_checks = 0;
    cyc(20);
    rst_n_i <= 1'b1;
    t_defaults();
    t_page();
    t_refcfg();
    t_charge();
    t_status();
    t_undervolt();
    results();
  end
endmodule
